//--- design/smpsr_pkg.sv
// constants and types of the speaker, mic bias and amp select bank
package smpsr_pkg;
   // ****************
   // register offsets
   // ****************
   localparam logic [7:0] OFS_LROUTE = 8'h2e;
   localparam logic [7:0] OFS_RROUTE = 8'h2f;
   localparam logic [7:0] OFS_SPKGAIN = 8'h30;
   localparam logic [7:0] OFS_RSVD_A = 8'h31;
   localparam logic [7:0] OFS_RSVD_B = 8'h32;
   localparam logic [7:0] OFS_BIAS = 8'h33;
   localparam logic [7:0] OFS_LPOS1 = 8'h34;
   localparam logic [7:0] OFS_LPOS2 = 8'h35;
   localparam logic [7:0] OFS_LNEG = 8'h36;
   localparam logic [7:0] OFS_RPOS1 = 8'h37;
   localparam logic [7:0] OFS_RPOS2 = 8'h38;
   // ****************
   // reset values
   // ****************
   localparam logic [6:0] ROUTE_RST = 7'h7f;
   localparam logic [2:0] GAIN_RST = 3'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [1:0] PAIR_RST = 2'h0;
   // ****************
   // field positions and code limits
   // ****************
   localparam int MASTER_BIT = 7;
   localparam int LGAIN_LSB = 4;
   localparam int RGAIN_LSB = 0;
   localparam int IN4A_BIT = 5;
   localparam int IN4B_BIT = 4;
   localparam logic [6:0] ROUTE_RSVD_LO = 7'h76;
   localparam logic [6:0] ROUTE_RSVD_HI = 7'h7e;
   localparam logic [6:0] ROUTE_DEEPEST = 7'h75;
   localparam logic [6:0] ROUTE_TBL_LO = 7'h1c;
   localparam logic [9:0] ATTEN_DEEPEST = 10'd783;
   localparam logic [9:0] ATTEN_LIN_STEP = 10'd5;
   localparam logic [2:0] GAIN_MAX = 3'h5;
   // ****************
   // bias control byte, same layout as the register
   // ****************
   typedef struct packed {
      logic ext_force;
      logic ext_pwr;
      logic [1:0] ext_lvl;
      logic ext_any_jack;
      logic int_pwr;
      logic [1:0] int_lvl;
   } smpsr_bias_t;
   // effective routing attenuation toward the analog path
   typedef struct packed {
      logic routed;
      logic [6:0] code;
      logic [9:0] atten;
   } smpsr_route_t;
endpackage

//--- design/smpsr_atten_lut.sv
// routing attenuation code to tenths of a dB lookup
`timescale 1ns/1ps
`default_nettype none
module smpsr_atten_lut
   import smpsr_pkg::*;
(
   // code in
   input wire logic [6:0] code,
   // decoded step
   output smpsr_route_t route
);
   // irregular steps from the first non-linear code upward
   localparam logic [9:0] ATT_TBL [0:89] = '{
      141, 146, 151, 156, 160, 165, 171, 175, 181, 186, 191, 196, 201, 206, 211,
      216, 221, 226, 231, 236, 241, 246, 251, 256, 261, 266, 271, 276, 281, 286,
      291, 296, 301, 306, 311, 316, 321, 327, 331, 336, 341, 346, 352, 357, 361,
      367, 371, 377, 382, 387, 392, 397, 402, 407, 412, 418, 421, 427, 432, 438,
      443, 448, 452, 458, 462, 467, 474, 479, 482, 487, 493, 500, 503, 510, 514,
      518, 523, 527, 537, 542, 554, 567, 583, 602, 627, 643, 662, 687, 723, 783};
   logic [6:0] tbl_idx;
   logic [9:0] lin_att;
   logic in_lin;
   logic in_tbl;
   // linear half-dB region, table region, reserved and off codes
   assign tbl_idx = code - ROUTE_TBL_LO;
   assign lin_att = 10'(code) * ATTEN_LIN_STEP;
   assign in_lin = code < ROUTE_TBL_LO;
   assign in_tbl = !in_lin && code <= ROUTE_DEEPEST;
   assign route.code = code;
   assign route.routed = in_lin || in_tbl;
   assign route.atten = in_lin ? lin_att : in_tbl ? ATT_TBL[tbl_idx] : 10'h000;
endmodule
`default_nettype wire

//--- design/smpsr_bias_ctl.sv
// mic bias supply power decision
`timescale 1ns/1ps
`default_nettype none
module smpsr_bias_ctl
   import smpsr_pkg::*;
(
   // control byte and jack state
   input wire smpsr_bias_t ctl,
   input wire logic jack_in,
   input wire logic mic_found,
   // supply requests
   output logic ext_on,
   output logic int_on
);
   logic jack_ok;
   // on insertion, bias needs a mic unless any-jack mode is set
   assign jack_ok = jack_in && (mic_found || ctl.ext_any_jack);
   // forced mode follows the power bit alone
   assign ext_on = ctl.ext_pwr && (ctl.ext_force || jack_ok);
   assign int_on = ctl.int_pwr;
endmodule
`default_nettype wire

//--- design/smpsr_regs.sv
// register bank for speaker routing, speaker gain, mic bias and amp input select
//
// Operation
// - right routing resets off; reserved codes refused
// - routing code maps to fixed attenuation step
// - left speaker gain resets muted, 6 dB steps
// - right speaker gain resets muted, 6 dB steps
// - two reserved locations read zero, read-only
// - forced mode ignores jack; else jack gates
// - power bit requests external bias on
// - two bits choose external bias level
// - any-jack mode skips mic detection
// - bit powers internal bias
// - two bits choose internal bias level
// - left positive select, four two-bit fields
// - fourth inputs to left terminals, 20K
// - left negative select, four two-bit fields
// - right positive select, four two-bit fields
// - fourth inputs to right terminals, 20K
// - master bit copies left routing to right
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module smpsr_regs
   import smpsr_pkg::*;
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [7:0] RDATA,
   // jack sense
   input wire logic JACK_INSERTED,
   input wire logic MIC_DETECTED,
   // speaker routing and gain
   output smpsr_route_t LEFT_LINE_OUTPUT_ROUTE,
   output smpsr_route_t RIGHT_LINE_OUTPUT_ROUTE,
   output logic [2:0] LEFT_SPEAKER_DRIVER_GAIN,
   output logic [2:0] RIGHT_SPEAKER_DRIVER_GAIN,
   // bias supplies
   output logic EXTERNAL_BIAS_SUPPLY_ON,
   output logic [1:0] EXTERNAL_BIAS_SUPPLY_LEVEL,
   output logic INTERNAL_BIAS_SUPPLY_ON,
   output logic [1:0] INTERNAL_BIAS_SUPPLY_LEVEL,
   // amp input select
   output logic [7:0] LEFT_POS_SELECT,
   output logic LEFT_POS_INPUT_FOUR_LEFT,
   output logic LEFT_NEG_INPUT_FOUR_RIGHT,
   output logic [7:0] LEFT_NEG_SELECT,
   output logic [7:0] RIGHT_POS_SELECT,
   output logic RIGHT_POS_INPUT_FOUR_RIGHT,
   output logic RIGHT_NEG_INPUT_FOUR_LEFT
);
   // ************************
   // helpers
   // ************************
   // routing code outside the reserved band
   function automatic logic route_ok(input logic [6:0] c);
      return !(c >= ROUTE_RSVD_LO && c <= ROUTE_RSVD_HI);
   endfunction
   // speaker gain code not reserved
   function automatic logic gain_ok(input logic [2:0] c);
      return c <= GAIN_MAX;
   endfunction

   // ************************
   // storage
   // ************************
   logic [6:0] lroute_r;
   logic [6:0] rroute_r;
   logic master_r;
   logic [2:0] lgain_r;
   logic [2:0] rgain_r;
   smpsr_bias_t bias_r;
   logic [7:0] lpos1_r;
   logic [1:0] lpos2_r;
   logic [7:0] lneg_r;
   logic [7:0] rpos1_r;
   logic [1:0] rpos2_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // ************************
   // write decode
   // ************************
   logic wr_lroute;
   logic wr_rroute;
   logic wr_gain;
   logic wr_bias;
   logic wr_lpos1;
   logic wr_lpos2;
   logic wr_lneg;
   logic wr_rpos1;
   logic wr_rpos2;
   logic wr_route_ok;
   logic wr_lgain_ok;
   logic wr_rgain_ok;
   assign wr_lroute = WR_STB && ADDR == OFS_LROUTE;
   assign wr_rroute = WR_STB && ADDR == OFS_RROUTE;
   assign wr_gain = WR_STB && ADDR == OFS_SPKGAIN;
   assign wr_bias = WR_STB && ADDR == OFS_BIAS;
   assign wr_lpos1 = WR_STB && ADDR == OFS_LPOS1;
   assign wr_lpos2 = WR_STB && ADDR == OFS_LPOS2;
   assign wr_lneg = WR_STB && ADDR == OFS_LNEG;
   assign wr_rpos1 = WR_STB && ADDR == OFS_RPOS1;
   assign wr_rpos2 = WR_STB && ADDR == OFS_RPOS2;
   // reserved codes never reach the fields
   assign wr_route_ok = route_ok(WDATA[6:0]);
   assign wr_lgain_ok = gain_ok(WDATA[LGAIN_LSB+:3]);
   assign wr_rgain_ok = gain_ok(WDATA[RGAIN_LSB+:3]);

   // routing registers, off after reset
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         lroute_r <= ROUTE_RST;
         rroute_r <= ROUTE_RST;
         master_r <= 1'b0;
      end else begin
         if (wr_lroute && wr_route_ok)
            lroute_r <= WDATA[6:0];
         if (wr_rroute && wr_route_ok)
            rroute_r <= WDATA[6:0];
         if (wr_rroute)
            master_r <= WDATA[MASTER_BIT];
      end
   end

   // speaker gain, muted after reset
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         lgain_r <= GAIN_RST;
         rgain_r <= GAIN_RST;
      end else begin
         if (wr_gain && wr_lgain_ok)
            lgain_r <= WDATA[LGAIN_LSB+:3];
         if (wr_gain && wr_rgain_ok)
            rgain_r <= WDATA[RGAIN_LSB+:3];
      end
   end

   // bias control and amp select bytes
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         bias_r <= BYTE_RST;
         lpos1_r <= BYTE_RST;
         lpos2_r <= PAIR_RST;
         lneg_r <= BYTE_RST;
         rpos1_r <= BYTE_RST;
         rpos2_r <= PAIR_RST;
      end else begin
         if (wr_bias)
            bias_r <= WDATA;
         if (wr_lpos1)
            lpos1_r <= WDATA;
         if (wr_lpos2)
            lpos2_r <= {WDATA[IN4A_BIT], WDATA[IN4B_BIT]};
         if (wr_lneg)
            lneg_r <= WDATA;
         if (wr_rpos1)
            rpos1_r <= WDATA;
         if (wr_rpos2)
            rpos2_r <= {WDATA[IN4A_BIT], WDATA[IN4B_BIT]};
      end
   end

   // ************************
   // read path
   // ************************
   logic [7:0] rb_rroute;
   logic [7:0] rb_gain;
   logic [7:0] rb_pos2l;
   logic [7:0] rb_pos2r;
   // reserved bits read as their zero reset value
   assign rb_rroute = {master_r, rroute_r};
   assign rb_gain = {1'b0, lgain_r, 1'b0, rgain_r};
   assign rb_pos2l = {2'b00, lpos2_r, 4'h0};
   assign rb_pos2r = {2'b00, rpos2_r, 4'h0};
   always_comb begin
      rdata_nxt = 8'h00;
      if (RD_STB) begin
         unique case (ADDR)
            OFS_LROUTE: rdata_nxt = {1'b0, lroute_r};
            OFS_RROUTE: rdata_nxt = rb_rroute;
            OFS_SPKGAIN: rdata_nxt = rb_gain;
            OFS_BIAS: rdata_nxt = bias_r;
            OFS_LPOS1: rdata_nxt = lpos1_r;
            OFS_LPOS2: rdata_nxt = rb_pos2l;
            OFS_LNEG: rdata_nxt = lneg_r;
            OFS_RPOS1: rdata_nxt = rpos1_r;
            OFS_RPOS2: rdata_nxt = rb_pos2r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end
   // read data valid only in the cycle after the strobe
   always_ff @(posedge CLOCK) begin
      if (!RESET_N)
         rdata_r <= 8'h00;
      else
         rdata_r <= rdata_nxt;
   end
   assign RDATA = rdata_r;

   // ************************
   // analog control
   // ************************
   logic [6:0] rcode_eff;
   smpsr_route_t lroute_dec;
   smpsr_route_t rroute_dec;
   logic ext_on;
   logic int_on;
   // master mode feeds the left code to both sides
   assign rcode_eff = master_r ? lroute_r : rroute_r;
   smpsr_atten_lut u_lut_left (
      .code (lroute_r),
      .route (lroute_dec)
   );
   smpsr_atten_lut u_lut_right (
      .code (rcode_eff),
      .route (rroute_dec)
   );
   smpsr_bias_ctl u_bias (
      .ctl (bias_r),
      .jack_in (JACK_INSERTED),
      .mic_found (MIC_DETECTED),
      .ext_on (ext_on),
      .int_on (int_on)
   );
   // all analog controls leave from flip-flops
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         LEFT_LINE_OUTPUT_ROUTE <= '0;
         RIGHT_LINE_OUTPUT_ROUTE <= '0;
         EXTERNAL_BIAS_SUPPLY_ON <= 1'b0;
         INTERNAL_BIAS_SUPPLY_ON <= 1'b0;
      end else begin
         LEFT_LINE_OUTPUT_ROUTE <= lroute_dec;
         RIGHT_LINE_OUTPUT_ROUTE <= rroute_dec;
         EXTERNAL_BIAS_SUPPLY_ON <= ext_on;
         INTERNAL_BIAS_SUPPLY_ON <= int_on;
      end
   end
   // static codes, one cycle behind the store
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         LEFT_SPEAKER_DRIVER_GAIN <= GAIN_RST;
         RIGHT_SPEAKER_DRIVER_GAIN <= GAIN_RST;
         EXTERNAL_BIAS_SUPPLY_LEVEL <= PAIR_RST;
         INTERNAL_BIAS_SUPPLY_LEVEL <= PAIR_RST;
      end else begin
         LEFT_SPEAKER_DRIVER_GAIN <= lgain_r;
         RIGHT_SPEAKER_DRIVER_GAIN <= rgain_r;
         EXTERNAL_BIAS_SUPPLY_LEVEL <= bias_r.ext_lvl;
         INTERNAL_BIAS_SUPPLY_LEVEL <= bias_r.int_lvl;
      end
   end
   // input select outputs
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         LEFT_POS_SELECT <= BYTE_RST;
         LEFT_POS_INPUT_FOUR_LEFT <= 1'b0;
         LEFT_NEG_INPUT_FOUR_RIGHT <= 1'b0;
         LEFT_NEG_SELECT <= BYTE_RST;
         RIGHT_POS_SELECT <= BYTE_RST;
         RIGHT_POS_INPUT_FOUR_RIGHT <= 1'b0;
         RIGHT_NEG_INPUT_FOUR_LEFT <= 1'b0;
      end else begin
         LEFT_POS_SELECT <= lpos1_r;
         LEFT_POS_INPUT_FOUR_LEFT <= lpos2_r[1];
         LEFT_NEG_INPUT_FOUR_RIGHT <= lpos2_r[0];
         LEFT_NEG_SELECT <= lneg_r;
         RIGHT_POS_SELECT <= rpos1_r;
         RIGHT_POS_INPUT_FOUR_RIGHT <= rpos2_r[1];
         RIGHT_NEG_INPUT_FOUR_LEFT <= rpos2_r[0];
      end
   end

   // ************************
   // checks
   // ************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);

   property p_route_reset;
      disable iff (1'b0) !RESET_N |=> rroute_r == ROUTE_RST && lgain_r == GAIN_RST;
   endproperty
   a_route_reset: assert property (p_route_reset) else $error("reset values wrong");

   // master mode off on both sides, so the right output follows the right field alone
   property p_route_rsvd;
      wr_rroute && !route_ok(WDATA[6:0]) && !master_r && !WDATA[MASTER_BIT]
         |=> $stable(rroute_r) ##1 $stable(RIGHT_LINE_OUTPUT_ROUTE.code);
   endproperty
   a_route_rsvd: assert property (p_route_rsvd) else $error("reserved route code stored");

   property p_atten_deep;
      rcode_eff == ROUTE_DEEPEST |=> RIGHT_LINE_OUTPUT_ROUTE.atten == ATTEN_DEEPEST;
   endproperty
   a_atten_deep: assert property (p_atten_deep) else $error("deepest step wrong");

   property p_lgain;
      wr_gain |=> lgain_r == ($past(wr_lgain_ok) ? $past(WDATA[6:4]) : $past(lgain_r))
         ##1 LEFT_SPEAKER_DRIVER_GAIN == $past(lgain_r);
   endproperty
   a_lgain: assert property (p_lgain) else $error("left gain update wrong");

   property p_rgain;
      wr_gain && !wr_rgain_ok |=> $stable(rgain_r);
   endproperty
   a_rgain: assert property (p_rgain) else $error("reserved right gain stored");

   property p_rsvd_bits;
      RD_STB && ADDR == OFS_LPOS2 |=> RDATA[7:6] == 2'b00 && RDATA[3:0] == 4'h0;
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bits not zero");

   property p_rsvd_loc;
      RD_STB && (ADDR == OFS_RSVD_A || ADDR == OFS_RSVD_B) |=> RDATA == 8'h00;
   endproperty
   a_rsvd_loc: assert property (p_rsvd_loc) else $error("reserved location not zero");

   property p_ext_nojack;
      !bias_r.ext_force && !JACK_INSERTED |=> !EXTERNAL_BIAS_SUPPLY_ON;
   endproperty
   a_ext_nojack: assert property (p_ext_nojack) else $error("bias on without jack");

   property p_ext_force;
      bias_r.ext_force |=> EXTERNAL_BIAS_SUPPLY_ON == $past(bias_r.ext_pwr);
   endproperty
   a_ext_force: assert property (p_ext_force) else $error("forced bias wrong");

   property p_ext_mic;
      JACK_INSERTED && !MIC_DETECTED && !bias_r.ext_force
         |=> EXTERNAL_BIAS_SUPPLY_ON == ($past(bias_r.ext_any_jack) && $past(bias_r.ext_pwr));
   endproperty
   a_ext_mic: assert property (p_ext_mic) else $error("mic gating wrong");

   property p_int_on;
      wr_bias |=> ##1 INTERNAL_BIAS_SUPPLY_ON == $past(WDATA[2], 2);
   endproperty
   a_int_on: assert property (p_int_on) else $error("internal bias wrong");

   property p_master;
      master_r |=> RIGHT_LINE_OUTPUT_ROUTE.code == $past(lroute_r);
   endproperty
   a_master: assert property (p_master) else $error("master copy wrong");

   property p_readback;
      RD_STB && ADDR == OFS_BIAS |=> RDATA == $past(bias_r);
   endproperty
   a_readback: assert property (p_readback) else $error("bias readback wrong");

   property p_cv_rsvd;
      wr_rroute && !wr_route_ok;
   endproperty
   c_cv_rsvd: cover property (p_cv_rsvd);
   property p_cv_master;
      master_r && lroute_r != rroute_r;
   endproperty
   c_cv_master: cover property (p_cv_master);
   property p_cv_ext;
      JACK_INSERTED ##1 EXTERNAL_BIAS_SUPPLY_ON;
   endproperty
   c_cv_ext: cover property (p_cv_ext);
endmodule
`default_nettype wire

//--- verif/smpsr_host_model.sv
// host controller model driving the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module smpsr_host_model
   import smpsr_pkg::*;
(
   // clock
   input wire logic clock,
   // register port toward the bank
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr_stb,
   output logic rd_stb,
   input wire logic [7:0] rdata
);
   // ****************
   // idle bus at time zero
   // ****************
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end

   // reset values forced into reserved bit positions
   function automatic logic [7:0] keep_rsvd(input logic [7:0] a, input logic [7:0] d);
      case (a)
         OFS_LROUTE: keep_rsvd = d & 8'h7f;
         OFS_SPKGAIN: keep_rsvd = d & 8'h77;
         OFS_RSVD_A, OFS_RSVD_B: keep_rsvd = BYTE_RST;
         OFS_LPOS2, OFS_RPOS2: keep_rsvd = d & 8'h30;
         default: keep_rsvd = d;
      endcase
   endfunction

   // ****************
   // one-cycle write; obey low sends the byte raw
   // ****************
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic obey);
      @(posedge clock);
      addr <= a;
      wdata <= obey ? keep_rsvd(a, d) : d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      addr <= ~a; // released lines must not keep the last value
      wdata <= ~d;
   endtask

   // one-cycle read, data taken in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask
endmodule
`default_nettype wire

//--- verif/smpsr_regs_bench.sv
// self-checking testbench of the speaker, mic bias and amp select bank
`timescale 1ns/1ps
`default_nettype none
module smpsr_regs_bench
   import smpsr_pkg::*;
;
   // ****************
   // signals
   // ****************
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic jack = 1'b0;
   logic mic = 1'b0;
   logic [7:0] addr, wdata, rdata;
   logic wr_stb, rd_stb;
   smpsr_route_t lroute, rroute;
   logic [2:0] lgain, rgain;
   logic ext_on, int_on;
   logic [1:0] ext_lvl, int_lvl;
   logic [7:0] lpos, lneg, rpos;
   logic lpos4, lneg4, rpos4, rneg4;
   int failures = 0;
   int num_checks = 0;
   logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h10, 7'h1c, 7'h43, 7'h75};
   logic [9:0] attens [6] = '{10'h000, 10'h005, 10'h050, 10'h08d, 10'h150, 10'h30f};
   logic [7:0] rsv [3] = '{OFS_RSVD_A, OFS_RSVD_B, 8'h50};
   logic [7:0] sel_pat [2] = '{8'h1b, 8'he4};

   // 100 MHz clock
   always #5 clock = ~clock;

   smpsr_host_model smpsr_host_model_i (.clock(clock), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata));

   smpsr_regs smpsr_regs_i (.CLOCK(clock), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
      .RD_STB(rd_stb), .RDATA(rdata), .JACK_INSERTED(jack), .MIC_DETECTED(mic),
      .LEFT_LINE_OUTPUT_ROUTE(lroute), .RIGHT_LINE_OUTPUT_ROUTE(rroute), .LEFT_SPEAKER_DRIVER_GAIN(lgain),
      .RIGHT_SPEAKER_DRIVER_GAIN(rgain), .EXTERNAL_BIAS_SUPPLY_ON(ext_on), .EXTERNAL_BIAS_SUPPLY_LEVEL(ext_lvl),
      .INTERNAL_BIAS_SUPPLY_ON(int_on), .INTERNAL_BIAS_SUPPLY_LEVEL(int_lvl), .LEFT_POS_SELECT(lpos),
      .LEFT_POS_INPUT_FOUR_LEFT(lpos4), .LEFT_NEG_INPUT_FOUR_RIGHT(lneg4), .LEFT_NEG_SELECT(lneg),
      .RIGHT_POS_SELECT(rpos), .RIGHT_POS_INPUT_FOUR_RIGHT(rpos4), .RIGHT_NEG_INPUT_FOUR_LEFT(rneg4));

   // ****************
   // compare, access and closing tasks
   // ****************
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected read data at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [17:0] got, input logic [17:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected output at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      smpsr_host_model_i.rd(a, d);
      chk_byte(d, exp);
   endtask

   // outputs follow storage one edge later
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      $display("unexpected hang at %0t: got %h expected %h", $time, 1'b0, 1'b1);
      stop_test();
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      logic [7:0] b;
      logic [7:0] q;
      logic [2:0] el, er;
      logic e;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      // reset values of the whole bank
      rd_chk(OFS_LROUTE, 8'h7f);
      rd_chk(OFS_RROUTE, 8'h7f);
      for (int a = 8'h30; a <= 8'h38; a++) rd_chk(8'(a), BYTE_RST);
      chk_pin(rroute, {1'b0, ROUTE_RST, 10'h000});
      chk_pin({12'h000, lgain, rgain}, 18'h00000);
      // every gain code on both drivers, reserved codes ignored
      el = GAIN_RST;
      er = GAIN_RST;
      for (int c = 0; c < 8; c++) begin
         smpsr_host_model_i.wr(OFS_SPKGAIN, {1'b0, 3'(c), 1'b0, 3'(7 - c)}, 1'b1);
         if (3'(c) <= GAIN_MAX) el = 3'(c);
         if (3'(7 - c) <= GAIN_MAX) er = 3'(7 - c);
         settle();
         chk_pin({12'h000, lgain, rgain}, {12'h000, el, er});
         rd_chk(OFS_SPKGAIN, {1'b0, el, 1'b0, er});
      end
      smpsr_host_model_i.wr(OFS_SPKGAIN, 8'hff, 1'b0);
      rd_chk(OFS_SPKGAIN, {1'b0, el, 1'b0, er});
      // reserved and unmapped places stay zero
      foreach (rsv[k]) begin
         smpsr_host_model_i.wr(rsv[k], 8'hff, 1'b0);
         rd_chk(rsv[k], BYTE_RST);
      end
      // right routing steps, reserved codes refused
      for (int k = 0; k < 6; k++) begin
         smpsr_host_model_i.wr(OFS_RROUTE, {1'b0, codes[k]}, 1'b1);
         smpsr_host_model_i.wr(OFS_RROUTE, {1'b0, ROUTE_RSVD_LO}, 1'b1);
         smpsr_host_model_i.wr(OFS_RROUTE, {1'b0, ROUTE_RSVD_HI}, 1'b1);
         settle();
         chk_pin(rroute, {1'b1, codes[k], attens[k]});
      end
      // master bit copies left routing to right
      smpsr_host_model_i.wr(OFS_LROUTE, 8'hf5, 1'b0);
      smpsr_host_model_i.wr(OFS_RROUTE, 8'h90, 1'b1);
      settle();
      chk_pin(lroute, {1'b1, ROUTE_DEEPEST, ATTEN_DEEPEST});
      chk_pin(rroute, {1'b1, ROUTE_DEEPEST, ATTEN_DEEPEST});
      rd_chk(OFS_LROUTE, 8'h75);
      rd_chk(OFS_RROUTE, 8'h90);
      smpsr_host_model_i.wr(OFS_RROUTE, 8'h10, 1'b1);
      settle();
      chk_pin(rroute, {1'b1, 7'h10, 10'h050});
      smpsr_host_model_i.wr(OFS_RROUTE, 8'h7f, 1'b1);
      settle();
      chk_pin(rroute, {1'b0, ROUTE_RST, 10'h000});
      // bias control against jack and mic states
      for (int i = 0; i < 32; i++) begin
         b = {i[4], i[3], i[1:0], i[2], i[0] ^ i[1], i[3:2]};
         smpsr_host_model_i.wr(OFS_BIAS, b, 1'b1);
         @(posedge clock);
         jack <= i[1];
         mic <= i[0];
         settle();
         e = i[3] & (i[4] | (i[1] & (i[0] | i[2])));
         chk_pin({12'h000, ext_on, ext_lvl, int_on, int_lvl}, {12'h000, e, b[5:4], b[2], b[1:0]});
         rd_chk(OFS_BIAS, b);
      end
      // amp input select fields, all four codes in each byte, two codes per field
      foreach (sel_pat[k]) begin
         q = sel_pat[k];
         smpsr_host_model_i.wr(OFS_LPOS1, q, 1'b1);
         smpsr_host_model_i.wr(OFS_LNEG, ~q, 1'b1);
         smpsr_host_model_i.wr(OFS_RPOS1, {q[3:0], q[7:4]}, 1'b1);
         smpsr_host_model_i.wr(OFS_LPOS2, q, 1'b0);
         smpsr_host_model_i.wr(OFS_RPOS2, ~q, 1'b0);
         settle();
         chk_pin({2'h0, lpos, lneg}, {2'h0, q, ~q});
         chk_pin({6'h00, rpos, lpos4, lneg4, rpos4, rneg4}, {6'h00, q[3:0], q[7:4], q[5], q[4], ~q[5], ~q[4]});
         rd_chk(OFS_LPOS1, q);
         rd_chk(OFS_LNEG, ~q);
         rd_chk(OFS_RPOS1, {q[3:0], q[7:4]});
         rd_chk(OFS_LPOS2, q & 8'h30);
         rd_chk(OFS_RPOS2, ~q & 8'h30);
      end
      // read data return to zero after their one cycle
      @(posedge clock);
      #1;
      chk_byte(rdata, 8'h00);
      stop_test();
   end
endmodule
`default_nettype wire
